// ==== shared/diag_regs_pkg.sv ====
// Package with the register map, field layout, reset values and types of the diagnostic registers.
package diag_regs_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 14;
   localparam int CRC_W  = 16;
   localparam int TEMP_W = 10;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [IDX_W-1:0] IDX_PRI_LOW     = 14'h1d3b;
   localparam logic [IDX_W-1:0] IDX_HIGH        = 14'h1d3c;
   localparam logic [IDX_W-1:0] IDX_ALT_LOW     = 14'h1d3d;
   localparam logic [IDX_W-1:0] IDX_CTRL        = 14'h1d5f;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 14'h1d60;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 14'h1d61;
   localparam logic [IDX_W-1:0] IDX_FUSE_STATUS = 14'h1d62;

   // Field positions.
   localparam int HIGH_PRI_LSB      = 6;
   localparam int HIGH_ALT_LSB      = 0;
   localparam int CTRL_RETN_INJ_BIT = 0;
   localparam int CTRL_FUSE_INJ_BIT = 1;
   localparam int CTRL_FUSE_CLR_BIT = 2;
   localparam int IRQ_W             = 3;
   localparam int IRQ_RETN_BIT      = 0;
   localparam int IRQ_FUSE_BIT      = 1;
   localparam int IRQ_TEMP_BIT      = 2;

   // Values after reset.
   localparam logic [7:0]       TEMP_LOW_RESET   = 8'hff;
   localparam logic [1:0]       TEMP_UPPER_RESET = 2'h3;
   localparam logic [2:0]       CTRL_RESET       = 3'h0;
   localparam logic [IRQ_W-1:0] IRQ_RESET        = 3'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              valid;
      logic [TEMP_W-1:0] code;
   } temp_sample_t;

   typedef struct packed {
      logic             check;
      logic [CRC_W-1:0] calc;
      logic [CRC_W-1:0] stored;
   } crc_check_t;

   typedef enum logic [1:0] {
      WR_IDLE     = 2'b00,
      WR_GOT_ADDR = 2'b01,
      WR_GOT_DATA = 2'b10,
      WR_RESP     = 2'b11
   } wr_state_t;

   function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction : reg_index

   function automatic logic [CRC_W-1:0] corrupt_crc(input logic [CRC_W-1:0] calc,
                                                    input logic [CRC_W-1:0] stored,
                                                    input logic             inject);
      return inject ? ~stored : calc;
   endfunction : corrupt_crc
endpackage : diag_regs_pkg

// ==== logic/crc_compare.sv ====
// CRC comparison with optional forced corruption, one check per strobe.
module crc_compare
   import diag_regs_pkg::*;
(
   input  wire logic                      clk_sys_in,
   input  wire logic                      reset_in,
   input  wire diag_regs_pkg::crc_check_t check_in,
   input  wire logic                      inject_in,
   output logic                           mismatch_out
);
   import diag_regs_pkg::*;

   // With injection off the computed value passes unchanged, so only real mismatches flag.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         mismatch_out <= 1'b0;
      end else begin
         mismatch_out <= check_in.check &&
            (corrupt_crc(check_in.calc, check_in.stored, inject_in) != check_in.stored);
      end
   end
endmodule : crc_compare

// ==== logic/diag_temp_crc_inject_regs.sv ====
// Diagnostic temperature result and CRC fault injection registers behind an AXI4-Lite slave.
//
// Design decision made here: the AXI4-Lite register port.
module diag_temp_crc_inject_regs (
   input  wire logic                                clk_sys_in,
   input  wire logic                                reset_in,
   input  wire logic [diag_regs_pkg::ADDR_W-1:0]    s_axi_awaddr_in,
   input  wire logic                                s_axi_awvalid_in,
   output logic                                     s_axi_awready_out,
   input  wire logic [diag_regs_pkg::DATA_W-1:0]    s_axi_wdata_in,
   input  wire logic [3:0]                          s_axi_wstrb_in,
   input  wire logic                                s_axi_wvalid_in,
   output logic                                     s_axi_wready_out,
   output logic [1:0]                               s_axi_bresp_out,
   output logic                                     s_axi_bvalid_out,
   input  wire logic                                s_axi_bready_in,
   input  wire logic [diag_regs_pkg::ADDR_W-1:0]    s_axi_araddr_in,
   input  wire logic                                s_axi_arvalid_in,
   output logic                                     s_axi_arready_out,
   output logic [diag_regs_pkg::DATA_W-1:0]         s_axi_rdata_out,
   output logic [1:0]                               s_axi_rresp_out,
   output logic                                     s_axi_rvalid_out,
   input  wire logic                                s_axi_rready_in,
   input  wire diag_regs_pkg::temp_sample_t         primary_temp_in,
   input  wire diag_regs_pkg::temp_sample_t         alternate_temp_in,
   input  wire diag_regs_pkg::crc_check_t           fuse_crc_in,
   input  wire diag_regs_pkg::crc_check_t           retained_mem_crc_in,
   output logic                                     fuse_crc_error_out,
   output logic                                     irq_out
);
   import diag_regs_pkg::*;

   wr_state_t               wr_state_reg;
   wr_state_t               wr_state_next;
   logic [ADDR_W-1:0]       awaddr_hold_reg;
   logic [DATA_W-1:0]       wdata_hold_reg;
   logic [3:0]              wstrb_hold_reg;
   logic                    aw_hs;
   logic                    w_hs;
   logic                    ar_hs;
   logic                    wr_commit;
   logic [IDX_W-1:0]        wr_idx;
   logic [DATA_W-1:0]       wr_data;
   logic [3:0]              wr_strb;
   logic                    wr_lane0;
   logic                    rvalid_next;
   logic [TEMP_W-1:0]       primary_temp_reg;
   logic [TEMP_W-1:0]       alternate_temp_reg;
   logic [2:0]              ctrl_reg;
   logic                    fuse_status_reg;
   logic [IRQ_W-1:0]        irq_status_reg;
   logic [IRQ_W-1:0]        irq_mask_reg;
   logic [IRQ_W-1:0]        irq_events;
   logic                    fuse_mismatch;
   logic                    retn_mismatch;
   logic [DATA_W-1:0]       read_value;
   logic                    read_mapped;

   assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
   assign w_hs  = s_axi_wvalid_in && s_axi_wready_out;
   assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;

   crc_compare fuse_check (
      .clk_sys_in   (clk_sys_in),
      .reset_in     (reset_in),
      .check_in     (fuse_crc_in),
      .inject_in    (ctrl_reg[CTRL_FUSE_INJ_BIT]),
      .mismatch_out (fuse_mismatch)
   );

   crc_compare retention_check (
      .clk_sys_in   (clk_sys_in),
      .reset_in     (reset_in),
      .check_in     (retained_mem_crc_in),
      .inject_in    (ctrl_reg[CTRL_RETN_INJ_BIT]),
      .mismatch_out (retn_mismatch)
   );

   // Write channel sequencing; address and data may arrive in either order.
   always_comb begin
      wr_state_next = wr_state_reg;
      wr_commit     = 1'b0;
      case (wr_state_reg)
         WR_IDLE: begin
            if (aw_hs && w_hs) begin
               wr_commit     = 1'b1;
               wr_state_next = WR_RESP;
            end else if (aw_hs) begin
               wr_state_next = WR_GOT_ADDR;
            end else if (w_hs) begin
               wr_state_next = WR_GOT_DATA;
            end
         end
         WR_GOT_ADDR: begin
            if (w_hs) begin
               wr_commit     = 1'b1;
               wr_state_next = WR_RESP;
            end
         end
         WR_GOT_DATA: begin
            if (aw_hs) begin
               wr_commit     = 1'b1;
               wr_state_next = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready_in) begin
               wr_state_next = WR_IDLE;
            end
         end
         default: begin
            wr_state_next = WR_IDLE;
         end
      endcase
   end

   assign wr_idx   = reg_index((wr_state_reg == WR_GOT_ADDR) ? awaddr_hold_reg : s_axi_awaddr_in);
   assign wr_data  = (wr_state_reg == WR_GOT_DATA) ? wdata_hold_reg : s_axi_wdata_in;
   assign wr_strb  = (wr_state_reg == WR_GOT_DATA) ? wstrb_hold_reg : s_axi_wstrb_in;
   assign wr_lane0 = wr_commit && wr_strb[0];

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         wr_state_reg      <= WR_IDLE;
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out  <= 1'b1;
         awaddr_hold_reg   <= '0;
         wdata_hold_reg    <= '0;
         wstrb_hold_reg    <= '0;
      end else begin
         wr_state_reg      <= wr_state_next;
         s_axi_awready_out <= (wr_state_next == WR_IDLE) || (wr_state_next == WR_GOT_DATA);
         s_axi_wready_out  <= (wr_state_next == WR_IDLE) || (wr_state_next == WR_GOT_ADDR);
         if (aw_hs) begin
            awaddr_hold_reg <= s_axi_awaddr_in;
         end
         if (w_hs) begin
            wdata_hold_reg <= s_axi_wdata_in;
            wstrb_hold_reg <= s_axi_wstrb_in;
         end
      end
   end

   // Write response; read-only registers accept writes silently, holes answer an error.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= RESP_OKAY;
      end else if (wr_commit) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out  <= (wr_idx >= IDX_PRI_LOW && wr_idx <= IDX_ALT_LOW) ||
                             (wr_idx >= IDX_CTRL && wr_idx <= IDX_FUSE_STATUS) ?
                             RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // Results are held as the sensor's raw half-Kelvin code, never rescaled here.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         primary_temp_reg   <= {TEMP_UPPER_RESET, TEMP_LOW_RESET};
         alternate_temp_reg <= {TEMP_UPPER_RESET, TEMP_LOW_RESET};
      end else begin
         if (primary_temp_in.valid) begin
            primary_temp_reg <= primary_temp_in.code;
         end
         if (alternate_temp_in.valid) begin
            alternate_temp_reg <= alternate_temp_in.code;
         end
      end
   end

   // The clear bit stays set for exactly one cycle, long enough to reach the status flag.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg[CTRL_FUSE_CLR_BIT] <= wr_lane0 && (wr_idx == IDX_CTRL) &&
                                        wr_data[CTRL_FUSE_CLR_BIT];
         if (wr_lane0 && (wr_idx == IDX_CTRL)) begin
            ctrl_reg[CTRL_FUSE_INJ_BIT] <= wr_data[CTRL_FUSE_INJ_BIT];
            ctrl_reg[CTRL_RETN_INJ_BIT] <= wr_data[CTRL_RETN_INJ_BIT];
         end
      end
   end

   // A mismatch in the clearing cycle wins, so no real error is lost.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         fuse_status_reg    <= 1'b0;
         fuse_crc_error_out <= 1'b0;
      end else begin
         if (fuse_mismatch) begin
            fuse_status_reg <= 1'b1;
         end else if (ctrl_reg[CTRL_FUSE_CLR_BIT]) begin
            fuse_status_reg <= 1'b0;
         end
         fuse_crc_error_out <= fuse_status_reg;
      end
   end

   assign irq_events[IRQ_RETN_BIT] = retn_mismatch;
   assign irq_events[IRQ_FUSE_BIT] = fuse_mismatch;
   assign irq_events[IRQ_TEMP_BIT] = primary_temp_in.valid || alternate_temp_in.valid;

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         irq_status_reg <= IRQ_RESET;
         irq_mask_reg   <= IRQ_RESET;
         irq_out        <= 1'b0;
      end else begin
         if (wr_lane0 && (wr_idx == IDX_IRQ_STATUS)) begin
            irq_status_reg <= (irq_status_reg & ~wr_data[IRQ_W-1:0]) | irq_events;
         end else begin
            irq_status_reg <= irq_status_reg | irq_events;
         end
         if (wr_lane0 && (wr_idx == IDX_IRQ_MASK)) begin
            irq_mask_reg <= wr_data[IRQ_W-1:0];
         end
         irq_out <= |(irq_status_reg & irq_mask_reg);
      end
   end

   always_comb begin
      read_value  = '0;
      read_mapped = 1'b1;
      case (reg_index(s_axi_araddr_in))
         IDX_PRI_LOW: begin
            read_value[7:0] = primary_temp_reg[7:0];
         end
         IDX_HIGH: begin
            read_value[HIGH_PRI_LSB +: 2] = primary_temp_reg[TEMP_W-1:8];
            read_value[HIGH_ALT_LSB +: 2] = alternate_temp_reg[TEMP_W-1:8];
         end
         IDX_ALT_LOW: begin
            read_value[7:0] = alternate_temp_reg[7:0];
         end
         IDX_CTRL: begin
            read_value[2:0] = ctrl_reg;
         end
         IDX_IRQ_STATUS: begin
            read_value[IRQ_W-1:0] = irq_status_reg;
         end
         IDX_IRQ_MASK: begin
            read_value[IRQ_W-1:0] = irq_mask_reg;
         end
         IDX_FUSE_STATUS: begin
            read_value[0] = fuse_status_reg;
         end
         default: begin
            read_mapped = 1'b0;
         end
      endcase
   end

   assign rvalid_next = ar_hs ? 1'b1 : (s_axi_rvalid_out && s_axi_rready_in) ? 1'b0 :
                        s_axi_rvalid_out;

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         s_axi_rvalid_out  <= 1'b0;
         s_axi_arready_out <= 1'b1;
         s_axi_rdata_out   <= '0;
         s_axi_rresp_out   <= RESP_OKAY;
      end else begin
         s_axi_rvalid_out  <= rvalid_next;
         s_axi_arready_out <= !rvalid_next;
         if (ar_hs) begin
            s_axi_rdata_out <= read_value;
            s_axi_rresp_out <= read_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   property p_fuse_clear;
      @(posedge clk_sys_in) disable iff (reset_in)
      ctrl_reg[CTRL_FUSE_CLR_BIT] && !fuse_mismatch |=> !fuse_status_reg ##1 !fuse_crc_error_out;
   endproperty
   a_fuse_clear: assert property (p_fuse_clear)
      else $error("Fuse error status not cleared by clear bit.");

   property p_clear_self;
      @(posedge clk_sys_in) disable iff (reset_in)
      wr_lane0 && wr_idx == IDX_CTRL && wr_data[CTRL_FUSE_CLR_BIT]
      |=> ctrl_reg[CTRL_FUSE_CLR_BIT] ##1 !ctrl_reg[CTRL_FUSE_CLR_BIT];
   endproperty
   a_clear_self: assert property (p_clear_self)
      else $error("Fuse clear bit did not return to zero.");

   property p_fuse_inject;
      @(posedge clk_sys_in) disable iff (reset_in)
      fuse_crc_in.check && ctrl_reg[CTRL_FUSE_INJ_BIT] |=> ##1 fuse_status_reg;
   endproperty
   a_fuse_inject: assert property (p_fuse_inject)
      else $error("Injected fuse CRC error was not flagged.");

   property p_retn_inject;
      @(posedge clk_sys_in) disable iff (reset_in)
      retained_mem_crc_in.check && ctrl_reg[CTRL_RETN_INJ_BIT] |-> ##2 irq_status_reg[IRQ_RETN_BIT];
   endproperty
   a_retn_inject: assert property (p_retn_inject)
      else $error("Injected retention CRC error did not raise its flag.");

   property p_genuine_only;
      @(posedge clk_sys_in) disable iff (reset_in)
      fuse_crc_in.check && !ctrl_reg[CTRL_FUSE_INJ_BIT] && fuse_crc_in.calc == fuse_crc_in.stored
      |=> !fuse_mismatch;
   endproperty
   a_genuine_only: assert property (p_genuine_only)
      else $error("Fuse CRC flagged with matching values and no injection.");

   property p_high_read;
      @(posedge clk_sys_in) disable iff (reset_in)
      ar_hs && reg_index(s_axi_araddr_in) == IDX_HIGH
      |=> s_axi_rdata_out[7:6] == $past(primary_temp_reg[9:8])
          && s_axi_rdata_out[1:0] == $past(alternate_temp_reg[9:8])
          && s_axi_rdata_out[5:2] == 4'h0;
   endproperty
   a_high_read: assert property (p_high_read)
      else $error("High result register layout wrong.");

   property p_alt_reset;
      @(posedge clk_sys_in)
      reset_in ##1 !reset_in && !alternate_temp_in.valid |-> alternate_temp_reg[7:0] == 8'hff;
   endproperty
   a_alt_reset: assert property (p_alt_reset)
      else $error("Alternate low byte not all ones after reset.");

   property p_pri_capture;
      @(posedge clk_sys_in) disable iff (reset_in)
      primary_temp_in.valid |=> primary_temp_reg == $past(primary_temp_in.code)
                                && primary_temp_reg[7:0] == $past(primary_temp_in.code[7:0]);
   endproperty
   a_pri_capture: assert property (p_pri_capture)
      else $error("Primary temperature code not captured.");
endmodule : diag_temp_crc_inject_regs

// ==== verification/diag_temp_crc_inject_regs_tb.sv ====
// Self-checking testbench for the diagnostic temperature and CRC injection registers.
module diag_temp_crc_inject_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import diag_regs_pkg::*;

   logic                clk_sys_in = 1'b0;
   logic                reset_in   = 1'b1;
   logic [ADDR_W-1:0]   awaddr     = '0;
   logic                awvalid    = 1'b0;
   logic                awready;
   logic [DATA_W-1:0]   wdata      = '0;
   logic [3:0]          wstrb      = 4'h0;
   logic                wvalid     = 1'b0;
   logic                wready;
   logic [1:0]          bresp;
   logic                bvalid;
   logic                bready     = 1'b0;
   logic [ADDR_W-1:0]   araddr     = '0;
   logic                arvalid    = 1'b0;
   logic                arready;
   logic [DATA_W-1:0]   rdata;
   logic [1:0]          rresp;
   logic                rvalid;
   logic                rready     = 1'b0;
   temp_sample_t        pri_temp   = '0;
   temp_sample_t        alt_temp   = '0;
   crc_check_t          fuse_crc   = '0;
   crc_check_t          retn_crc   = '0;
   logic                fuse_err;
   logic                irq;
   int                  num_errors = 0;
   int                  n_checks   = 0;
   logic [DATA_W-1:0]   rd_val;
   logic [DATA_W-1:0]   hi_val;

   localparam logic [IDX_W-1:0] IDX_UNMAPPED = 14'h1d50;

   always #25 clk_sys_in = ~clk_sys_in;

   diag_temp_crc_inject_regs i_diag_temp_crc_inject_regs (
      .clk_sys_in          (clk_sys_in),
      .reset_in            (reset_in),
      .s_axi_awaddr_in     (awaddr),
      .s_axi_awvalid_in    (awvalid),
      .s_axi_awready_out   (awready),
      .s_axi_wdata_in      (wdata),
      .s_axi_wstrb_in      (wstrb),
      .s_axi_wvalid_in     (wvalid),
      .s_axi_wready_out    (wready),
      .s_axi_bresp_out     (bresp),
      .s_axi_bvalid_out    (bvalid),
      .s_axi_bready_in     (bready),
      .s_axi_araddr_in     (araddr),
      .s_axi_arvalid_in    (arvalid),
      .s_axi_arready_out   (arready),
      .s_axi_rdata_out     (rdata),
      .s_axi_rresp_out     (rresp),
      .s_axi_rvalid_out    (rvalid),
      .s_axi_rready_in     (rready),
      .primary_temp_in     (pri_temp),
      .alternate_temp_in   (alt_temp),
      .fuse_crc_in         (fuse_crc),
      .retained_mem_crc_in (retn_crc),
      .fuse_crc_error_out  (fuse_err),
      .irq_out             (irq)
   );

   task automatic close_out();
      $display("Checks: %0d, errors: %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // The master holds each channel until its own handshake edge; the wait is bounded.
   task automatic axi_wr(input logic [IDX_W-1:0] idx, input logic [7:0] data,
                         input logic [1:0] exp_resp);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h0, data};
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, exp_resp}, "write response");
      if (n >= 50) begin
         chk(32'h0, 32'h1, "write timeout");
         close_out();
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [IDX_W-1:0] idx, input logic [1:0] exp_resp,
                         output logic [DATA_W-1:0] data);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      data = rdata;
      rready <= 1'b0;
      chk({30'h0, rresp}, {30'h0, exp_resp}, "read response");
      if (n >= 50) begin
         chk(32'h0, 32'h1, "read timeout");
         close_out();
      end
   endtask : axi_rd

   task automatic crc_pulse(input bit fuse, input logic [CRC_W-1:0] calc,
                            input logic [CRC_W-1:0] stored);
      @(posedge clk_sys_in);
      if (fuse) fuse_crc <= '{check: 1'b1, calc: calc, stored: stored};
      else retn_crc <= '{check: 1'b1, calc: calc, stored: stored};
      @(posedge clk_sys_in);
      fuse_crc.check <= 1'b0;
      retn_crc.check <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
   endtask : crc_pulse

   task automatic t_reset_values();
      axi_rd(IDX_PRI_LOW, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_00ff, "primary low after reset");
      axi_rd(IDX_HIGH, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_00c3, "high bits after reset");
      axi_rd(IDX_ALT_LOW, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_00ff, "alternate low after reset");
      axi_rd(IDX_CTRL, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_0000, "control after reset");
   endtask : t_reset_values

   // A die at 295 K reads back as code 590; the alternate code is picked to split its fields.
   task automatic t_temperature();
      @(posedge clk_sys_in);
      pri_temp <= '{valid: 1'b1, code: 10'(295 * 2)};
      alt_temp <= '{valid: 1'b1, code: 10'h1a5};
      @(posedge clk_sys_in);
      pri_temp.valid <= 1'b0;
      alt_temp.valid <= 1'b0;
      axi_wr(IDX_PRI_LOW, 8'h00, RESP_OKAY);
      axi_wr(IDX_ALT_LOW, 8'h00, RESP_OKAY);
      axi_rd(IDX_HIGH, RESP_OKAY, hi_val);
      chk(hi_val, 32'h0000_0081, "high bits after sample");
      axi_rd(IDX_PRI_LOW, RESP_OKAY, rd_val);
      chk({22'h0, hi_val[7:6], rd_val[7:0]} / 2, 32'd295, "kelvin");
      axi_rd(IDX_ALT_LOW, RESP_OKAY, rd_val);
      chk({22'h0, hi_val[1:0], rd_val[7:0]}, 32'h0000_01a5, "alternate result");
      axi_rd(IDX_IRQ_STATUS, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_0004, "temperature event");
      axi_wr(IDX_IRQ_STATUS, 8'h04, RESP_OKAY);
      axi_rd(IDX_UNMAPPED, RESP_SLVERR, rd_val);
      chk(rd_val, 32'h0, "unmapped read data");
      axi_wr(IDX_UNMAPPED, 8'hff, RESP_SLVERR);
   endtask : t_temperature

   task automatic t_fuse();
      crc_pulse(1'b1, 16'h1234, 16'h1234);
      chk({31'h0, fuse_err}, 32'h0, "fuse error on match");
      crc_pulse(1'b1, 16'h1234, 16'h1235);
      chk({31'h0, fuse_err}, 32'h1, "fuse error on mismatch");
      axi_wr(IDX_CTRL, 8'h04, RESP_OKAY);
      repeat (3) @(posedge clk_sys_in);
      chk({31'h0, fuse_err}, 32'h0, "fuse error after clear");
      axi_rd(IDX_CTRL, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0, "clear bit returns to zero");
      axi_wr(IDX_CTRL, 8'h02, RESP_OKAY);
      crc_pulse(1'b1, 16'h5555, 16'h5555);
      chk({31'h0, fuse_err}, 32'h1, "forced fuse error");
      axi_rd(IDX_CTRL, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_0002, "fuse inject bit held");
      axi_rd(IDX_IRQ_STATUS, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_0002, "fuse event");
      axi_wr(IDX_CTRL, 8'h04, RESP_OKAY);
      repeat (3) @(posedge clk_sys_in);
      chk({31'h0, fuse_err}, 32'h0, "fuse error cleared again");
      axi_wr(IDX_IRQ_STATUS, 8'h07, RESP_OKAY);
   endtask : t_fuse

   // The interrupt line must follow mask and status both ways, not only rise once.
   task automatic t_retention();
      axi_wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
      crc_pulse(1'b0, 16'h0f0f, 16'h0f0f);
      chk({31'h0, irq}, 32'h0, "no retention fault on match");
      axi_wr(IDX_CTRL, 8'h01, RESP_OKAY);
      crc_pulse(1'b0, 16'h0f0f, 16'h0f0f);
      chk({31'h0, irq}, 32'h1, "forced retention fault");
      axi_rd(IDX_IRQ_STATUS, RESP_OKAY, rd_val);
      chk(rd_val, 32'h0000_0001, "retention event");
      axi_wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
      repeat (3) @(posedge clk_sys_in);
      chk({31'h0, irq}, 32'h0, "masked retention fault");
      axi_wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
      axi_wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
      axi_wr(IDX_CTRL, 8'h00, RESP_OKAY);
      repeat (3) @(posedge clk_sys_in);
      chk({31'h0, irq}, 32'h0, "retention fault cleared");
   endtask : t_retention

   initial begin
      repeat (5000) @(posedge clk_sys_in);
      num_errors++;
      $display("Error at %0t ns: watchdog expired", $time);
      close_out();
   end

   initial begin
      repeat (20) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      t_reset_values();
      t_temperature();
      t_fuse();
      t_retention();
      close_out();
   end
endmodule : diag_temp_crc_inject_regs_tb
